// *** verilog/vc_resource_ctl_status.sv ***
// control and status registers of the single virtual channel resource of a switch port
`timescale 1ns/100ps
`include "vc_resource_defs.svh"

module vc_resource_ctl_status #(
  parameter bit UPSTREAM = 1'b1
) (
  // clock and reset
  input  wire logic                          i_clock,
  input  wire logic                          i_reset,
  // register port
  input  wire vc_resource_pkg::reg_req_t     i_req,
  output logic [31:0]                        o_rdata,
  // arbitration table and arbiter
  input  wire logic                          i_table_write,
  input  wire vc_resource_pkg::phase_table_t i_table_entries,
  output vc_resource_pkg::phase_table_t      o_arb_phases,
  output logic                               o_arb_load,
  output logic [2:0]                         o_arb_scheme_select,
  output logic                               o_arb_table_pending,
  // traffic class mapping
  output logic [7:0]                         o_class_to_channel_map,
  // link layer
  input  wire vc_resource_pkg::link_state_t  i_link,
  output logic                               o_negotiation_pending
);
  import vc_resource_pkg::*;

  localparam logic [7:0] CAPABILITY =
    UPSTREAM ? `VCR_CAP_UPSTREAM : `VCR_CAP_DOWNSTREAM;

  state_t state_reg;
  state_t state_next;

  // a scheme uses the table only if the capability advertises it and it is not the hardware fixed round robin
  function automatic logic scheme_uses_table(input logic [2:0] sel,
                                             input logic [7:0] cap);
    logic supported;
    supported = cap[sel];
    return supported && (sel != 3'h0);
  endfunction

  function automatic logic [31:0] control_word(input state_t s);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`VCR_MAP_MSB:`VCR_MAP_LSB] = s.class_to_channel_map;
    w[`VCR_LOAD_BIT]             = 1'b0;
    w[`VCR_SEL_MSB:`VCR_SEL_LSB] = s.arb_scheme_select;
    w[`VCR_ID_MSB:`VCR_ID_LSB]   = `VCR_ID_VALUE;
    w[`VCR_ENABLE_BIT]           = `VCR_ENABLE_VALUE;
    return w;
  endfunction

  function automatic logic [31:0] status_word(input state_t s);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`VCR_TABLE_PEND_BIT] = UPSTREAM && s.arb_table_pending_status;
    w[`VCR_NEG_PEND_BIT]   = s.negotiation_pending;
    return w;
  endfunction

  always_comb begin
    logic ctl_hit;
    logic sts_hit;
    logic load_req;
    ctl_hit  = (i_req.addr == `VCR_CONTROL_OFFSET);
    sts_hit  = (i_req.addr == `VCR_STATUS_OFFSET);
    load_req = 1'b0;

    state_next = state_reg;
    state_next.arb_load_pulse = 1'b0;

    // control register write
    if (i_req.wr && ctl_hit) begin
      // class zero can never be unmapped
      state_next.class_to_channel_map =
        i_req.wdata[`VCR_MAP_MSB:`VCR_MAP_LSB] | `VCR_MAP_FIXED_MASK;
      // no legality check: software keeps to the advertised schemes
      state_next.arb_scheme_select = i_req.wdata[`VCR_SEL_MSB:`VCR_SEL_LSB];
      // judged on the scheme being written in the same word
      load_req = UPSTREAM && i_req.wdata[`VCR_LOAD_BIT] &&
                 scheme_uses_table(i_req.wdata[`VCR_SEL_MSB:`VCR_SEL_LSB],
                                   CAPABILITY);
    end

    // table load sequencer
    unique case (state_reg.load_state)
      LOAD_IDLE: begin
        if (load_req) begin
          state_next.load_state = LOAD_COPY;
        end
      end
      LOAD_COPY: begin
        // all phases latched together, never a mix of old and new
        state_next.arb_phases     = i_table_entries;
        state_next.arb_load_pulse = 1'b1;
        state_next.arb_table_pending_status = 1'b0;
        if (!load_req) begin
          state_next.load_state = LOAD_IDLE;
        end
      end
    endcase

    // a table write beats the completing load, the copy may be stale
    if (i_table_write && UPSTREAM) begin
      state_next.arb_table_pending_status = 1'b1;
    end

    // flow control negotiation tracking
    state_next.fc_init2_seen = i_link.fc_init2;
    if (!i_link.dl_active && !i_link.fc_init2) begin
      // link retrains: negotiation starts over
      state_next.negotiation_pending = 1'b1;
    end
    if (state_reg.fc_init2_seen && !i_link.fc_init2) begin
      state_next.negotiation_pending = 1'b0;
    end

    // read data stand for exactly the cycle after the strobe
    state_next.rdata = 32'h0000_0000;
    if (i_req.rd) begin
      if (ctl_hit) begin
        state_next.rdata = control_word(state_reg);
      end else if (sts_hit) begin
        state_next.rdata = status_word(state_reg);
      end
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      state_reg.class_to_channel_map     <= `VCR_MAP_RESET;
      state_reg.arb_scheme_select        <= `VCR_SEL_RESET;
      state_reg.arb_table_pending_status <= 1'b0;
      state_reg.negotiation_pending      <= 1'b0;
      state_reg.fc_init2_seen            <= 1'b0;
      state_reg.load_state               <= LOAD_IDLE;
      state_reg.arb_load_pulse           <= 1'b0;
      state_reg.arb_phases               <= '0;
      state_reg.rdata                    <= 32'h0000_0000;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_rdata                = state_reg.rdata;
  assign o_arb_phases           = state_reg.arb_phases;
  assign o_arb_load             = state_reg.arb_load_pulse;
  assign o_arb_scheme_select    = state_reg.arb_scheme_select;
  assign o_arb_table_pending    = UPSTREAM && state_reg.arb_table_pending_status;
  assign o_class_to_channel_map = state_reg.class_to_channel_map;
  assign o_negotiation_pending  = state_reg.negotiation_pending;

endmodule

// *** verilog/vc_resource_defs.svh ***
// offsets, field positions, reset values and sizes of the channel resource registers
`ifndef VC_RESOURCE_DEFS_SVH
`define VC_RESOURCE_DEFS_SVH

// register bus geometry
`define VCR_ADDR_W            12
`define VCR_DATA_W            32

// register offsets (byte addresses)
`define VCR_CONTROL_OFFSET    12'h0214
`define VCR_STATUS_OFFSET     12'h0218

// control register fields
`define VCR_MAP_LSB           0
`define VCR_MAP_MSB           7
`define VCR_MAP_RESET         8'hFF
`define VCR_MAP_FIXED_MASK    8'h01
`define VCR_LOAD_BIT          16
`define VCR_SEL_LSB           17
`define VCR_SEL_MSB           19
`define VCR_SEL_RESET         3'h0
`define VCR_ID_LSB            24
`define VCR_ID_MSB            26
`define VCR_ID_VALUE          3'h0
`define VCR_ENABLE_BIT        31
`define VCR_ENABLE_VALUE      1'h1

// status register fields
`define VCR_TABLE_PEND_BIT    16
`define VCR_NEG_PEND_BIT      17

// arbitration capability per port kind
`define VCR_CAP_UPSTREAM      8'h03
`define VCR_CAP_DOWNSTREAM    8'h01
`define VCR_CAP_W             8

// arbitration table geometry
`define VCR_PHASES            32
`define VCR_PORT_ID_W         4

`endif

// *** verilog/vc_resource_pkg.sv ***
// types shared by the channel resource control and status registers
package vc_resource_pkg;

  // register port request from configuration space
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  // link layer state seen by the block
  typedef struct packed {
    logic dl_active;
    logic fc_init2;
  } link_state_t;

  // table load sequencer
  typedef enum logic [0:0] {
    LOAD_IDLE,
    LOAD_COPY
  } load_state_t;

  typedef logic [31:0][3:0] phase_table_t;

  // all state of the block
  typedef struct packed {
    logic [7:0]   class_to_channel_map;
    logic [2:0]   arb_scheme_select;
    logic         arb_table_pending_status;
    logic         negotiation_pending;
    logic         fc_init2_seen;
    load_state_t  load_state;
    logic         arb_load_pulse;
    phase_table_t arb_phases;
    logic [31:0]  rdata;
  } state_t;

endpackage

// *** testbench/vc_resource_props.sv ***
// assertions on the ports of the channel resource register block
`timescale 1ns/100ps
module vc_resource_props import vc_resource_pkg::*; #(
  parameter bit UPSTREAM = 1'b1
) (
  input wire logic         i_clock,
  input wire logic         i_reset,
  input wire reg_req_t     i_req,
  input wire logic [31:0]  o_rdata,
  input wire logic         i_table_write,
  input wire phase_table_t i_table_entries,
  input wire phase_table_t o_arb_phases,
  input wire logic         o_arb_load,
  input wire logic         o_arb_table_pending,
  input wire logic [7:0]   o_class_to_channel_map,
  input wire link_state_t  i_link,
  input wire logic         o_negotiation_pending
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_reset);
  // only a select of one uses the table, so only it may trigger a copy
  wire trig = i_req.wr && i_req.addr == 12'h0214 && i_req.wdata[16]
              && i_req.wdata[19:17] == 3'h1 && UPSTREAM;
  map_bit0_a: assert property (o_class_to_channel_map[0]) else $error("class zero unmapped");
  rdata_idle_a: assert property (!$past(i_req.rd) |-> o_rdata == 32'h0000_0000) else $error("stray read data");
  ctl_fixed_a: assert property ($past(i_req.rd && i_req.addr == 12'h0214)
    |-> {o_rdata[31:24], o_rdata[16]} == 9'h100) else $error("fixed control bits wrong");
  load_two_a: assert property (trig |-> ##2 o_arb_load) else $error("load missing");
  load_cause_a: assert property (o_arb_load |-> $past(trig, 2)) else $error("load without cause");
  phases_hold_a: assert property (!o_arb_load |-> $stable(o_arb_phases)) else $error("phases moved");
  phases_copy_a: assert property (o_arb_load |-> o_arb_phases == $past(i_table_entries))
    else $error("phases not copied");
  pend_set_a: assert property (UPSTREAM && i_table_write |=> o_arb_table_pending) else $error("status not set");
  pend_clear_a: assert property (o_arb_load && !$past(i_table_write) |-> !o_arb_table_pending)
    else $error("status not cleared");
  down_zero_a: assert property (!UPSTREAM |-> !o_arb_table_pending) else $error("downstream status set");
  neg_clear_a: assert property ($fell(i_link.fc_init2) |-> ##[0:1] !o_negotiation_pending)
    else $error("negotiation not cleared");
endmodule

bind vc_resource_ctl_status vc_resource_props #(.UPSTREAM(UPSTREAM)) i_props (.i_clock, .i_reset,
  .i_req, .o_rdata, .i_table_write, .i_table_entries, .o_arb_phases, .o_arb_load,
  .o_arb_table_pending, .o_class_to_channel_map, .i_link, .o_negotiation_pending);

// *** testbench/tb_top.sv ***
// self-checking bench for the channel resource register block
`timescale 1ns/100ps
module tb_top;
  import vc_resource_pkg::*;
  logic         clk = 1'b0, rst = 1'b1, twr = 1'b0;
  reg_req_t     req = '0;
  link_state_t  lnk = 2'b10;
  phase_table_t ent = '0, ph;
  logic [31:0]  rdata;
  logic         ld, pend, neg, dld, dpend;
  logic [2:0]   sel;
  logic [7:0]   map;
  int           n_errors = 0, comparisons = 0;
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end
  vc_resource_ctl_status #(.UPSTREAM(1'b1)) i_dut (.i_clock(clk), .i_reset(rst), .i_req(req),
    .o_rdata(rdata), .i_table_write(twr), .i_table_entries(ent), .o_arb_phases(ph),
    .o_arb_load(ld), .o_arb_scheme_select(sel), .o_arb_table_pending(pend),
    .o_class_to_channel_map(map), .i_link(lnk), .o_negotiation_pending(neg));
  // downstream twin shares every input
  vc_resource_ctl_status #(.UPSTREAM(1'b0)) i_dn (.i_clock(clk), .i_reset(rst), .i_req(req),
    .o_rdata(), .i_table_write(twr), .i_table_entries(ent), .o_arb_phases(),
    .o_arb_load(dld), .o_arb_scheme_select(), .o_arb_table_pending(dpend),
    .o_class_to_channel_map(), .i_link(lnk), .o_negotiation_pending());
  initial forever #5 clk = ~clk;
  task wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk); req.addr <= a; req.wdata <= d; req.wr <= 1'b1;
    @(posedge clk); req.wr <= 1'b0;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e, input string nm);
    @(posedge clk); req.addr <= a; req.rd <= 1'b1;
    @(posedge clk); req.rd <= 1'b0;
    #1 `CHK(nm, e, rdata)
  endtask
  task end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task t_reset;
    rd(12'h0214, 32'h8000_00FF, "ctl reset");
    rd(12'h0218, 32'h0000_0000, "sts reset");
    rd(12'h021C, 32'h0000_0000, "unmapped");
    $display("t_reset done");
  endtask
  task t_map;
    wr(12'h0214, 32'h0000_0000);
    rd(12'h0214, 32'h8000_0001, "map zero");
    `CHK("map port", 8'h01, map)
    // trigger with scheme zero must not copy
    wr(12'h0214, 32'h7F01_FF5A);
    rd(12'h0214, 32'h8000_005B, "map sel0");
    $display("t_map done");
  endtask
  task t_neg;
    @(posedge clk); lnk <= 2'b00;
    rd(12'h0218, 32'h0002_0000, "neg set");
    @(posedge clk); lnk <= 2'b11;
    @(posedge clk); lnk <= 2'b10;
    @(posedge clk); @(posedge clk);
    #1 `CHK("neg clear", 1'b0, neg)
    $display("t_neg done");
  endtask
  task t_load;
    @(posedge clk); twr <= 1'b1; ent <= {8{16'hF3A1}};
    @(posedge clk); twr <= 1'b0;
    rd(12'h0218, 32'h0001_0000, "pend set");
    `CHK("dn pend", 1'b0, dpend)
    wr(12'h0214, 32'h0003_00FF);
    // pulse stands in the cycle after the copy edge only
    @(posedge clk);
    #1 `CHK("load", 1'b1, ld)
    `CHK("sel port", 3'h1, sel)
    `CHK("phases", {8{16'hF3A1}}, ph)
    `CHK("pend clr", 1'b0, pend)
    `CHK("dn load", 1'b0, dld)
    // table write in the copy cycle keeps the status set
    wr(12'h0214, 32'h0003_00FF); twr <= 1'b1;
    @(posedge clk); twr <= 1'b0;
    @(posedge clk);
    #1 `CHK("pend kept", 1'b1, pend)
    rd(12'h0214, 32'h8002_00FF, "ctl sel1");
    $display("t_load done");
  endtask
  initial begin
    #100000;
    n_errors++;
    end_of_test;
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_map;
    t_neg;
    t_load;
    end_of_test;
  end
endmodule
